/* src/dscd_core.sv */
// Purpose: Decodes and runs disk commands written as a CDB over APB.
// Assumes: Drive side answers each started operation with op_done.
// Notes:   Data-in bytes are taken one per read of the data register.
`timescale 1ns/1ps
// Behaviour
// - Inquiry sends exactly requested length, none if zero
// - Inquiry reports type 00, qualifier 80, revision 00
// - Bytes past 05 zero, byte 04 count, switches
// - Inquiry leaves unit attention untouched
// - Inquiry byte 00 always zero for any unit
// - Start/stop bit selects spin up or down
// - Spin up refused without vertical lever and cartridge
// - Stop under inhibit keeps light flashing, bezel locked
// - Start/stop off-line releases bus, else on-line
// - Start/stop bit 7 disables dwell seeks
// - Diagnostic runs off-line until finished
// - Diagnostic accepts one form, else illegal
// - Inhibit stops bezel polling until allow or reset
// - Prevent/allow bit sets or clears inhibit
// - Capacity returns address then size 256
// - Capacity relative bit gives invalid request
// - Extended read address, count, zero count harmless
// - Extended write relative bit is illegal
// - Write-verify checks CRC, bits 0/1 illegal
// - Read long sends suspect block then checks
module dscd_core (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output      logic [31:0]             prdata,
	output      logic                    pready,
	output      logic                    pslverr,
	input  wire dscd_pkg::dscd_drv_in_t  drv_in,
	output      dscd_pkg::dscd_drv_out_t drv_out
);
	import dscd_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	dscd_state_t   state, next_state;
	dscd_drv_out_t next_cmd;
	logic [7:0]    cdb [0:9];
	logic [7:0]    next_cdb [0:9];
	logic [7:0]    es, next_es;
	logic [3:0]    sense, next_sense;
	logic          done, next_done;
	logic [15:0]   idx, next_idx;
	logic [15:0]   left, next_left;
	logic [31:0]   cap, next_cap;
	logic [1:0]    attn, next_attn;
	logic          is_inq, next_is_inq;
	logic [31:0]   next_prdata;
	logic          next_pready;
	logic          next_pslverr;
	logic          acc_wr;
	logic          acc_rd;
	logic          go;
	logic          hrst;
	logic          done_clr;
	logic          pop;
	logic          busy;
	logic          lun;
	logic [7:0]    op;
	logic [7:0]    cur_byte;
	logic [15:0]   blocks;

	assign busy   = state != S_IDLE;
	assign lun    = cdb[1][5];
	assign op     = cdb[0];
	assign blocks = {cdb[7], cdb[8]};
	assign acc_wr = psel & penable & pready & pwrite & ~pslverr;
	assign acc_rd = psel & penable & pready & ~pwrite & ~pslverr;
	assign go       = acc_wr & (paddr == A_CTRL) & pwdata[CTRL_GO];
	assign hrst     = acc_wr & (paddr == A_CTRL) & pwdata[CTRL_HRST];
	assign done_clr = acc_wr & (paddr == A_STAT) & pwdata[ST_DONE];
	assign pop      = acc_rd & (paddr == A_DATA) & (state == S_DIN);

	// ****************************************
	// Data-in byte source
	// ****************************************
	function automatic logic [7:0] byte_at(
		input logic        inq,
		input logic [15:0] i,
		input logic [7:0]  alen,
		input logic [7:0]  sw,
		input logic [31:0] c
	);
		logic [7:0] b;
		b = 8'h00;
		if (inq) begin
			case (i)
				16'h0000: b = INQ_TYPE;
				16'h0001: b = INQ_QUAL;
				16'h0002: b = INQ_REV;
				16'h0004: b = (alen > INQ_LAST) ? alen - INQ_LAST : 8'h00;
				16'h0005: b = sw;
				default:  b = 8'h00;
			endcase
		end else begin
			case (i)
				16'h0000: b = c[31:24];
				16'h0001: b = c[23:16];
				16'h0002: b = c[15:8];
				16'h0003: b = c[7:0];
				16'h0004: b = CAP_BLK[31:24];
				16'h0005: b = CAP_BLK[23:16];
				16'h0006: b = CAP_BLK[15:8];
				16'h0007: b = CAP_BLK[7:0];
				default:  b = 8'h00;
			endcase
		end
		return b;
	endfunction : byte_at

	assign cur_byte = byte_at(is_inq, idx, cdb[4], drv_in.switches, cap);

	// ****************************************
	// APB slave
	// ****************************************
	always_comb begin
		logic hit;
		hit = 1'b1;
		next_prdata  = RST_WORD;
		next_pready  = psel & penable & ~pready;
		for (int k = 0; k < 10; k++) begin
			next_cdb[k] = cdb[k];
		end
		if (paddr == A_CDB0) begin
			next_prdata = {cdb[3], cdb[2], cdb[1], cdb[0]};
		end else if (paddr == A_CDB1) begin
			next_prdata = {cdb[7], cdb[6], cdb[5], cdb[4]};
		end else if (paddr == A_CDB2) begin
			next_prdata = {16'h0000, cdb[9], cdb[8]};
		end else if (paddr == A_CTRL) begin
			next_prdata = RST_WORD;
		end else if (paddr == A_STAT) begin
			next_prdata = {12'h000, sense, 4'h0, done,
				drv_out.off_line, state == S_DIN, busy, es};
		end else if (paddr == A_DATA) begin
			next_prdata = {24'h000000,
				(state == S_DIN) ? cur_byte : 8'h00};
		end else if (paddr == A_DRV) begin
			next_prdata = {22'h000000, attn, drv_out.flash,
				drv_out.inhibit, drv_out.dwell_off, drv_out.spin};
		end else begin
			hit = 1'b0;
		end
		if (~next_pready | pwrite) begin
			next_prdata = RST_WORD;
		end
		next_pslverr = next_pready & ~hit;
		// The CDB is frozen while a command runs.
		if (acc_wr & ~busy) begin
			if (paddr == A_CDB0) begin
				next_cdb[0] = pwdata[7:0];
				next_cdb[1] = pwdata[15:8];
				next_cdb[2] = pwdata[23:16];
				next_cdb[3] = pwdata[31:24];
			end else if (paddr == A_CDB1) begin
				next_cdb[4] = pwdata[7:0];
				next_cdb[5] = pwdata[15:8];
				next_cdb[6] = pwdata[23:16];
				next_cdb[7] = pwdata[31:24];
			end else if (paddr == A_CDB2) begin
				next_cdb[8] = pwdata[7:0];
				next_cdb[9] = pwdata[15:8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			for (int k = 0; k < 10; k++) begin
				cdb[k] <= 8'h00;
			end
		end else begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
			for (int k = 0; k < 10; k++) begin
				cdb[k] <= next_cdb[k];
			end
		end
	end

	// ****************************************
	// Command engine
	// ****************************************
	always_comb begin
		logic [3:0] err;
		err         = SK_NONE;
		next_state  = state;
		next_es     = es;
		next_sense  = sense;
		next_idx    = idx;
		next_left   = left;
		next_cap    = cap;
		next_is_inq = is_inq;
		next_cmd    = drv_out;
		next_cmd.diag_go = 1'b0;
		next_cmd.xfer_go = 1'b0;
		// Hardware set wins over software clear.
		next_done = done & ~done_clr;
		next_attn = attn | drv_in.attn_evt;
		case (state)
			S_IDLE: begin
				if (go) begin
					next_state = S_DEC;
				end
			end
			S_DEC: begin
				next_state   = S_END;
				next_cmd.lun = lun;
				next_idx     = 16'h0000;
				next_is_inq  = op == OP_INQ;
				if (op != OP_INQ && attn[lun]) begin
					err = SK_ATTN;
					next_attn[lun] = drv_in.attn_evt[lun];
				end else if (op == OP_INQ) begin
					next_left = {8'h00, cdb[4]};
					if (cdb[4] != 8'h00) begin
						next_state = S_DIN;
					end
				end else if (op == OP_SS) begin
					if (cdb[4][0] &
						~(drv_in.lever_up[lun] & drv_in.cart_in[lun])) begin
						err = SK_NOTRDY;
					end else begin
						next_cmd.spin[lun] = cdb[4][0];
						next_cmd.dwell_off[lun] = cdb[5][7];
						next_cmd.off_line = cdb[1][0];
						next_state = S_WAIT;
					end
				end else if (op == OP_DIAG) begin
					if (cdb[2] != DIAG_FORM) begin
						err = SK_ILLEGAL;
					end else begin
						next_cmd.diag_go  = 1'b1;
						next_cmd.off_line = 1'b1;
						next_state = S_WAIT;
					end
				end else if (op == OP_PREV) begin
					next_cmd.inhibit[lun] = cdb[4][0];
				end else if (op == OP_CAP) begin
					if (cdb[1][0]) begin
						err = SK_INVALID;
					end else begin
						next_cap = cdb[8][0] ? drv_in.trk_last
							: drv_in.last_lba;
						next_left  = 16'h0008;
						next_state = S_DIN;
					end
				end else if (op == OP_RD || op == OP_RL ||
					op == OP_WR || op == OP_WV) begin
					if (cdb[1][0] || (op == OP_WV && cdb[1][1])) begin
						err = SK_ILLEGAL;
					end else if (blocks != 16'h0000) begin
						next_cmd.lba     = {cdb[2], cdb[3], cdb[4], cdb[5]};
						next_cmd.count   = blocks;
						next_cmd.xfer_wr = op == OP_WR || op == OP_WV;
						next_cmd.verify  = op == OP_WV;
						next_cmd.long_rd = op == OP_RL;
						next_cmd.xfer_go = 1'b1;
						next_state = S_WAIT;
					end
				end else begin
					err = SK_ILLEGAL;
				end
				if (err != SK_NONE) begin
					next_state = S_END;
				end
				next_es    = (err == SK_NONE) ? ES_GOOD : ES_CHECK;
				next_sense = err;
			end
			S_DIN: begin
				if (pop) begin
					next_idx  = idx + 16'h0001;
					next_left = left - 16'h0001;
					if (left == 16'h0001) begin
						next_state = S_END;
					end
				end
			end
			S_WAIT: begin
				if (drv_in.op_done) begin
					if (drv_in.crc_err && op != OP_SS && op != OP_DIAG) begin
						next_es    = ES_CHECK;
						next_sense = SK_MEDIA;
					end
					next_state = S_END;
				end
			end
			S_END: begin
				next_done = 1'b1;
				next_cmd.off_line = 1'b0;
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		if (hrst) begin
			next_cmd.inhibit = 2'b00;
		end
		next_cmd.flash = next_cmd.inhibit & ~next_cmd.spin;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= S_IDLE;
			es      <= 8'h00;
			sense   <= 4'h0;
			done    <= 1'b0;
			idx     <= 16'h0000;
			left    <= 16'h0000;
			cap     <= 32'h0000_0000;
			attn    <= 2'b00;
			is_inq  <= 1'b0;
			drv_out <= '0;
		end else begin
			state   <= next_state;
			es      <= next_es;
			sense   <= next_sense;
			done    <= next_done;
			idx     <= next_idx;
			left    <= next_left;
			cap     <= next_cap;
			attn    <= next_attn;
			is_inq  <= next_is_inq;
			drv_out <= next_cmd;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking dscd_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	inq_len_zero_a: assert property (
		state == S_DEC && op == OP_INQ && cdb[4] == 8'h00
		|=> state == S_END ##1 state == S_IDLE)
		else $error("zero length inquiry entered data phase");
	inq_header_a: assert property (
		state == S_DIN && is_inq && idx == 16'h0001
		|-> cur_byte == 8'h80)
		else $error("inquiry qualifier byte wrong");
	inq_tail_zero_a: assert property (
		state == S_DIN && is_inq && idx > 16'h0005
		|-> cur_byte == 8'h00)
		else $error("inquiry byte past five not zero");
	inq_attn_keep_a: assert property (
		state == S_DEC && op == OP_INQ && drv_in.attn_evt == 2'b00
		|=> attn == $past(attn))
		else $error("inquiry changed unit attention");
	inq_first_zero_a: assert property (
		state == S_DIN && is_inq && idx == 16'h0000
		|-> cur_byte == 8'h00)
		else $error("inquiry first byte not zero");
	spin_follow_a: assert property (
		state == S_DEC && op == OP_SS && !attn[lun] && !cdb[4][0]
		|=> !drv_out.spin[drv_out.lun] && state == S_WAIT)
		else $error("stop did not spin drive down");
	spin_refuse_a: assert property (
		state == S_DEC && op == OP_SS && cdb[4][0] &&
		!drv_in.cart_in[lun]
		|=> $stable(drv_out.spin) ##1 es == 8'h02)
		else $error("spin up allowed without cartridge");
	stop_locked_a: assert property (
		state == S_DEC && op == OP_SS && !attn[lun] && !cdb[4][0] &&
		drv_out.inhibit[lun] && !hrst
		|=> drv_out.inhibit[drv_out.lun] && drv_out.flash[drv_out.lun])
		else $error("stop under inhibit unlocked bezel or light");
	inhibit_hold_a: assert property (
		$fell(drv_out.inhibit[0])
		|-> $past(hrst) || $past(state) == S_DEC)
		else $error("inhibit dropped without allow or reset");
	cap_reject_a: assert property (
		state == S_DEC && op == OP_CAP && !attn[lun] && cdb[1][0]
		|=> state == S_END && es == 8'h02 && sense == SK_INVALID)
		else $error("relative capacity not rejected");
	cap_size_a: assert property (
		state == S_DIN && !is_inq && idx == 16'h0006
		|-> cur_byte == 8'h01)
		else $error("block size byte wrong");
	zero_count_a: assert property (
		state == S_DEC && op == OP_RD && !attn[lun] && !cdb[1][0] &&
		blocks == 16'h0000 |=> !drv_out.xfer_go && es == 8'h00)
		else $error("zero count read moved data");
	wv_reject_a: assert property (
		state == S_DEC && op == OP_WV && !attn[lun] && cdb[1][1]
		|=> !drv_out.xfer_go && es == 8'h02 ##1 state == S_IDLE)
		else $error("write-verify option not rejected");
	long_crc_a: assert property (
		state == S_WAIT && drv_in.op_done && drv_in.crc_err &&
		drv_out.long_rd |=> es == 8'h02 ##1 done)
		else $error("read long crc not reported");
	diag_offline_a: assert property (
		drv_out.diag_go |-> drv_out.off_line && state == S_WAIT)
		else $error("diagnostic not run off-line");

	inq_run_c: cover property (
		state == S_DIN && is_inq ##[1:40] state == S_IDLE);
	cap_run_c: cover property (state == S_DIN && !is_inq && pop);
	xfer_run_c: cover property (drv_out.xfer_go ##[1:50] done);
	stop_lock_c: cover property (drv_out.flash[0]);
endmodule : dscd_core

/* src/dscd_pkg.sv */
// Purpose: Shared constants and carriers for the disk command decoder.
// Assumes: 32-bit APB, byte addresses, two drives behind the controller.
// Notes:   Register offsets are byte addresses of aligned words.
package dscd_pkg;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [11:0] A_CDB0 = 12'h000;
	localparam logic [11:0] A_CDB1 = 12'h004;
	localparam logic [11:0] A_CDB2 = 12'h008;
	localparam logic [11:0] A_CTRL = 12'h00C;
	localparam logic [11:0] A_STAT = 12'h010;
	localparam logic [11:0] A_DATA = 12'h014;
	localparam logic [11:0] A_DRV  = 12'h018;
	localparam int CTRL_GO   = 0;
	localparam int CTRL_HRST = 1;
	localparam int ST_DONE   = 11;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// ****************************************
	// Command codes and fixed answers
	// ****************************************
	localparam logic [7:0] OP_INQ  = 8'h12;
	localparam logic [7:0] OP_SS   = 8'h1B;
	localparam logic [7:0] OP_DIAG = 8'h1D;
	localparam logic [7:0] OP_PREV = 8'h1E;
	localparam logic [7:0] OP_CAP  = 8'h25;
	localparam logic [7:0] OP_RD   = 8'h28;
	localparam logic [7:0] OP_WR   = 8'h2A;
	localparam logic [7:0] OP_WV   = 8'h2E;
	localparam logic [7:0] OP_RL   = 8'h3E;
	localparam logic [7:0] DIAG_FORM = 8'h04;
	localparam logic [7:0] INQ_TYPE  = 8'h00;
	localparam logic [7:0] INQ_QUAL  = 8'h80;
	localparam logic [7:0] INQ_REV   = 8'h00;
	localparam logic [7:0] INQ_LAST  = 8'h05;
	localparam logic [31:0] CAP_BLK  = 32'h0000_0100;
	localparam logic [7:0] ES_GOOD  = 8'h00;
	localparam logic [7:0] ES_CHECK = 8'h02;
	localparam logic [3:0] SK_NONE    = 4'h0;
	localparam logic [3:0] SK_NOTRDY  = 4'h2;
	localparam logic [3:0] SK_MEDIA   = 4'h3;
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [3:0] SK_ATTN    = 4'h6;
	localparam logic [3:0] SK_INVALID = 4'h7;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_DEC  = 6'b000010,
		S_DIN  = 6'b000100,
		S_WAIT = 6'b001000,
		S_END  = 6'b010000,
		S_SPARE = 6'b100000
	} dscd_state_t;
	typedef struct packed {
		logic [1:0]  lever_up;
		logic [1:0]  cart_in;
		logic [1:0]  attn_evt;
		logic [7:0]  switches;
		logic [31:0] last_lba;
		logic [31:0] trk_last;
		logic        op_done;
		logic        crc_err;
	} dscd_drv_in_t;
	typedef struct packed {
		logic        lun;
		logic [1:0]  spin;
		logic [1:0]  dwell_off;
		logic [1:0]  inhibit;
		logic [1:0]  flash;
		logic        diag_go;
		logic        xfer_go;
		logic        xfer_wr;
		logic        verify;
		logic        long_rd;
		logic [31:0] lba;
		logic [15:0] count;
		logic        off_line;
	} dscd_drv_out_t;
endpackage : dscd_pkg

/* tb/dscd_drive_model.sv */
// Purpose: Drive-side model answering spins, diagnostics and transfers.
// Assumes: Every started operation ends with one op_done pulse.
// Notes:   crc_err toggles when it does not qualify op_done.
`timescale 1ns/1ps
module dscd_drive_model #(
	parameter logic [7:0]  SW   = 8'h00,
	parameter logic [31:0] LAST = 32'h0000_0000,
	parameter logic [31:0] TRK  = 32'h0000_0000,
	parameter int          LAT  = 12
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire dscd_pkg::dscd_drv_out_t drv_out,
	input  wire logic                    kick,
	input  wire logic                    crc_mode,
	input  wire logic [1:0]              lever,
	input  wire logic [1:0]              cart,
	input  wire logic [1:0]              attn,
	output      dscd_pkg::dscd_drv_in_t  drv_in
);
	import dscd_pkg::*;
	int   cnt;
	logic done_q;
	logic tog;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			done_q <= 1'b0;
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
			done_q <= (cnt == 1);
			if (drv_out.xfer_go || drv_out.diag_go || kick)
				cnt <= LAT;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
	always_comb begin
		drv_in.lever_up = lever;
		drv_in.cart_in = cart;
		drv_in.attn_evt = attn;
		drv_in.switches = SW;
		drv_in.last_lba = LAST;
		drv_in.trk_last = TRK;
		drv_in.op_done = done_q;
		drv_in.crc_err = done_q ? crc_mode : tog;
	end
endmodule : dscd_drive_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the disk command decoder.
// Assumes: APB master per hand-over timing, drive model on far side.
// Notes:   Each scenario task drives and judges its own commands.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module testbench;
	import dscd_pkg::*;
	localparam logic [7:0]  SW   = 8'hA5;
	localparam logic [31:0] LAST = 32'h0001_2345;
	localparam logic [31:0] TRK  = 32'h0000_003F;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic          kick, crc_mode, err;
	logic [1:0]    lever, cart, attn;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, r;
	dscd_drv_in_t  drv_in;
	dscd_drv_out_t drv_out, cap;
	int            fails, n_compared;
	dscd_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drv_in(drv_in), .drv_out(drv_out));
	dscd_drive_model #(.SW(SW), .LAST(LAST), .TRK(TRK), .LAT(12)) mdl_u (
		.pclk(pclk), .presetn(presetn), .drv_out(drv_out), .kick(kick),
		.crc_mode(crc_mode), .lever(lever), .cart(cart), .attn(attn),
		.drv_in(drv_in));
	always @(posedge pclk) if (drv_out.xfer_go === 1'b1) cap <= drv_out;
	// ****************************************
	// Bus and command helpers
	// ****************************************
	function automatic logic [79:0] c6(logic [7:0] op, b1, b2, b4, b5);
		return {32'h0, b5, b4, 8'h00, b2, b1, op};
	endfunction : c6
	function automatic logic [79:0] c10(logic [7:0] op, b1,
		logic [31:0] a, logic [15:0] n);
		return {8'h00, n[7:0], n[15:8], 8'h00, a[7:0], a[15:8], a[23:16],
			a[31:24], b1, op};
	endfunction : c10
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic go(input logic [79:0] c);
		apb(1'b1, A_CDB0, c[31:0]);
		apb(1'b1, A_CDB1, c[63:32]);
		apb(1'b1, A_CDB2, {16'h0000, c[79:64]});
		apb(1'b1, A_CTRL, 32'h0000_0001);
	endtask : go
	task automatic fin(input logic [7:0] es, input logic [3:0] sk);
		do begin
			apb(1'b0, A_STAT, 32'h0);
		end while (r[ST_DONE] !== 1'b1);
		`CHK("ending status", es, r[7:0])
		`CHK("sense", sk, r[19:16])
		`CHK("data phase", 1'b0, r[9])
		apb(1'b1, A_STAT, 32'h0000_0800);
	endtask : fin
	task automatic din(input logic [7:0] e);
		apb(1'b0, A_DATA, 32'h0);
		`CHK("data byte", e, r[7:0])
	endtask : din
	task automatic rd8(input logic [63:0] v);
		for (int i = 7; i >= 0; i--) din(v[i*8 +: 8]);
	endtask : rd8
	task automatic drv(input logic [9:0] e);
		apb(1'b0, A_DRV, 32'h0);
		`CHK("drive state", e, r[9:0])
	endtask : drv
	task automatic kick_op();
		kick <= 1'b1;
		@(posedge pclk);
		kick <= 1'b0;
	endtask : kick_op
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_inq();
		attn <= 2'b10;
		@(posedge pclk);
		attn <= 2'b00;
		go(c6(OP_INQ, 8'h20, 8'h00, 8'h07, 8'h00));
		din(INQ_TYPE);
		din(INQ_QUAL);
		din(INQ_REV);
		din(8'h00);
		din(8'h02);
		din(SW);
		din(8'h00);
		fin(ES_GOOD, SK_NONE);
		go(c6(OP_INQ, 8'h20, 8'h00, 8'h00, 8'h00));
		fin(ES_GOOD, SK_NONE);
		drv(10'h200);
		go(c6(OP_PREV, 8'h20, 8'h00, 8'h00, 8'h00));
		fin(ES_CHECK, SK_ATTN);
		drv(10'h000);
	endtask : t_inq
	task automatic t_spin();
		go(c6(OP_SS, 8'h00, 8'h00, 8'h01, 8'h00));
		fin(ES_CHECK, SK_NOTRDY);
		drv(10'h000);
		lever <= 2'b11;
		cart <= 2'b11;
		go(c6(OP_SS, 8'h01, 8'h00, 8'h01, 8'h80));
		kick_op();
		apb(1'b0, A_STAT, 32'h0);
		`CHK("off-line wait", 1'b1, r[10])
		fin(ES_GOOD, SK_NONE);
		drv(10'h005);
		go(c6(OP_PREV, 8'h00, 8'h00, 8'h01, 8'h00));
		fin(ES_GOOD, SK_NONE);
		go(c6(OP_SS, 8'h00, 8'h00, 8'h00, 8'h00));
		kick_op();
		apb(1'b0, A_STAT, 32'h0);
		`CHK("on-line wait", 1'b0, r[10])
		fin(ES_GOOD, SK_NONE);
		drv(10'h050);
		apb(1'b1, A_CTRL, 32'h0000_0002);
		drv(10'h000);
		go(c6(OP_PREV, 8'h00, 8'h00, 8'h01, 8'h00));
		fin(ES_GOOD, SK_NONE);
		go(c6(OP_PREV, 8'h00, 8'h00, 8'h00, 8'h00));
		fin(ES_GOOD, SK_NONE);
		drv(10'h000);
		go(c6(OP_PREV, 8'h00, 8'h00, 8'h01, 8'h00));
		fin(ES_GOOD, SK_NONE);
		// A power-on reset in mid-run must also end the inhibit.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		drv(10'h000);
	endtask : t_spin
	task automatic t_diag();
		go(c6(OP_DIAG, 8'h00, DIAG_FORM, 8'h00, 8'h00));
		apb(1'b0, A_STAT, 32'h0);
		`CHK("diag off-line", 1'b1, r[10])
		`CHK("diag busy", 1'b1, r[8])
		fin(ES_GOOD, SK_NONE);
		go(c6(OP_DIAG, 8'h00, 8'h00, 8'h00, 8'h00));
		fin(ES_CHECK, SK_ILLEGAL);
	endtask : t_diag
	task automatic t_cap();
		go(c10(OP_CAP, 8'h01, 32'h0, 16'h0000));
		fin(ES_CHECK, SK_INVALID);
		go(c10(OP_CAP, 8'h00, 32'h0, 16'h0000));
		rd8({LAST, CAP_BLK});
		fin(ES_GOOD, SK_NONE);
		go(c10(OP_CAP, 8'h00, 32'h0000_0010, 16'h0001));
		rd8({TRK, CAP_BLK});
		fin(ES_GOOD, SK_NONE);
	endtask : t_cap
	task automatic t_xfer();
		logic [15:0] bad [4];
		bad = '{{OP_RD, 8'h01}, {OP_WR, 8'h01}, {OP_WV, 8'h01},
			{OP_WV, 8'h02}};
		go(c10(OP_RD, 8'h00, 32'h0102_0304, 16'h0000));
		fin(ES_GOOD, SK_NONE);
		go(c10(OP_RD, 8'h20, 32'hA1B2_C3D4, 16'h0203));
		fin(ES_GOOD, SK_NONE);
		`CHK("read unit", 1'b1, cap.lun)
		`CHK("read lba", 32'hA1B2_C3D4, cap.lba)
		`CHK("read count", 16'h0203, cap.count)
		`CHK("read dir", 1'b0, cap.xfer_wr)
		go(c10(OP_WR, 8'h00, 32'h0000_0100, 16'h0001));
		fin(ES_GOOD, SK_NONE);
		`CHK("write lba", 32'h0000_0100, cap.lba)
		`CHK("write dir", 1'b1, cap.xfer_wr)
		crc_mode <= 1'b1;
		go(c10(OP_WV, 8'h00, 32'h0000_0200, 16'h0001));
		fin(ES_CHECK, SK_MEDIA);
		`CHK("verify", 1'b1, cap.verify)
		go(c10(OP_RL, 8'h00, 32'h0000_0300, 16'h0001));
		fin(ES_CHECK, SK_MEDIA);
		`CHK("long read", 1'b1, cap.long_rd)
		crc_mode <= 1'b0;
		go(c10(OP_RL, 8'h00, 32'h0000_0300, 16'h0001));
		fin(ES_GOOD, SK_NONE);
		for (int i = 0; i < 4; i++) begin
			go(c10(bad[i][15:8], bad[i][7:0], 32'h0, 16'h0001));
			fin(ES_CHECK, SK_ILLEGAL);
		end
	endtask : t_xfer
	task automatic t_map();
		apb(1'b0, 12'h01C, 32'h0);
		`CHK("unmapped error", 1'b1, err)
		go(c6(8'h00, 8'h00, 8'h00, 8'h00, 8'h00));
		fin(ES_CHECK, SK_ILLEGAL);
	endtask : t_map
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// ****************************************
	// Clock, reset and run
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		conclude();
	end
	initial begin
		{presetn, psel, penable, pwrite, kick, crc_mode} = '0;
		{lever, cart, attn} = '0;
		paddr = '0;
		pwdata = '0;
		fails = 0;
		n_compared = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_inq();
		t_spin();
		t_diag();
		t_cap();
		t_xfer();
		t_map();
		conclude();
	end
endmodule : testbench
